//--- ccu_defines.svh
// Register map, field positions, reset values and timing counts of the checksum unit.
// Assumes inclusion by the package and the design modules.
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

`define CCU_OFS_DATA     8'h00
`define CCU_OFS_SCRATCH  8'h04
`define CCU_OFS_CTRL     8'h08
`define CCU_POLY         32'h04C11DB7
`define CCU_DATA_RESET   32'hFFFFFFFF
`define CCU_SCR_RESET    8'h00
`define CCU_CTRL_PRESET  0
`define CCU_CALC_CYCLES  3'h4
`define CCU_BITS_PER_CYC 8

`endif

//--- ccu_pkg.sv
// Types shared by the checksum unit modules.
// Assumes the defines header is available on the include path.
`include "ccu_defines.svh"

package ccu_pkg;

  typedef enum logic [1:0]
  {
    CCU_IDLE = 2'h0,
    CCU_BUSY = 2'h1
  } ccu_state_e;

  typedef logic [31:0] ccu_word_t;

endpackage

//--- ccu_step.sv
// One calculation step: folds eight input bits into the checksum, most significant first.
// Assumes the caller sequences four steps per word.
`timescale 1ns/10ps
`include "ccu_defines.svh"

module ccu_step
#(
  parameter int BITS = `CCU_BITS_PER_CYC
)
(
  input  wire logic [31:0]   crc_i,   // Current checksum
  input  wire logic [BITS-1:0] data_i, // Input bits, MSB first
  output logic      [31:0]   crc_o    // Updated checksum
);
  import ccu_pkg::*;

  logic [31:0] chain [0:BITS];

  assign chain[0] = crc_i;

  genvar g;
  generate
    for (g = 0; g < BITS; g++)
    begin : g_bit
      logic fb;
      assign fb = chain[g][31] ^ data_i[BITS-1-g];
      assign chain[g+1] = {chain[g][30:0], 1'b0} ^ ({32{fb}} & `CCU_POLY);
    end
  endgenerate

  assign crc_o = chain[BITS];

endmodule // ccu_step

//--- ccu_top.sv
// Checksum unit top: register port, input buffer and four-cycle calculation engine.
// Assumes a word-wide register port clocked by sys_clk_i; the master waits on nothing.
`timescale 1ns/10ps
`include "ccu_defines.svh"

module ccu_top
(
  input  wire logic          sys_clk_i,  // System clock, 40 MHz
  input  wire logic          rst_i,      // Synchronous reset, active high
  input  wire logic          sel_i,      // Register access select
  input  wire logic          write_i,    // 1 for write, 0 for read
  input  wire logic [7:0]    addr_i,     // Byte offset of register
  input  wire logic [31:0]   wdata_i,    // Write data
  output logic      [31:0]   rdata_o,    // Read data, registered
  output logic               busy_o      // Calculation in progress
);
  import ccu_pkg::*;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic wr_data;
  logic wr_scr;
  logic wr_ctrl;
  logic rd_data;
  logic rd_scr;
  logic rd_ctrl;
  logic rd_none;

  always_comb
  begin
    wr_data = 1'b0;
    wr_scr  = 1'b0;
    wr_ctrl = 1'b0;
    if (sel_i && write_i && addr_i == `CCU_OFS_DATA)
    begin
      wr_data = 1'b1;
    end
    else if (sel_i && write_i && addr_i == `CCU_OFS_SCRATCH)
    begin
      wr_scr = 1'b1;
    end
    else if (sel_i && write_i && addr_i == `CCU_OFS_CTRL)
    begin
      wr_ctrl = 1'b1;
    end
  end

  // A read of an unmapped offset still answers, with zero.
  always_comb
  begin
    rd_data = 1'b0;
    rd_scr  = 1'b0;
    rd_ctrl = 1'b0;
    rd_none = 1'b0;
    if (sel_i && !write_i && addr_i == `CCU_OFS_DATA)
    begin
      rd_data = 1'b1;
    end
    else if (sel_i && !write_i && addr_i == `CCU_OFS_SCRATCH)
    begin
      rd_scr = 1'b1;
    end
    else if (sel_i && !write_i && addr_i == `CCU_OFS_CTRL)
    begin
      rd_ctrl = 1'b1;
    end
    else if (sel_i && !write_i)
    begin
      rd_none = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  // A write is always taken; one word waits here while a calculation runs.
  ccu_word_t  buf_r;
  logic       buf_full_r;
  ccu_state_e state_r;
  logic [2:0] cnt_r;
  ccu_word_t  shift_r;
  ccu_word_t  crc_r;
  ccu_word_t  step_out;
  logic       start;
  logic       preset;
  logic       preset_r;
  logic       last_step;
  logic       crc_en;
  logic [7:0] step_in;

  assign preset = wr_ctrl && wdata_i[`CCU_CTRL_PRESET];
  assign start  = buf_full_r && (state_r == CCU_IDLE);

  // A preset drops a buffered word, so a write just before it never counts.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || preset)
    begin
      buf_full_r <= 1'b0;
    end
    else if (wr_data)
    begin
      buf_full_r <= 1'b1;
    end
    else if (start)
    begin
      buf_full_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || preset)
    begin
      buf_r <= '0;
    end
    else if (wr_data)
    begin
      buf_r <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Calculation engine
  // ----------------------------------------------------------------
  // The first step runs on the edge that takes the word from the buffer and
  // the other three run from the shift register, so all four steps of a word
  // written on one edge are folded in by the fourth edge after it. A second
  // word waits in the buffer until the engine has gone idle.
  assign last_step = (state_r == CCU_BUSY) && (cnt_r == 3'h1);
  assign step_in   = (state_r == CCU_BUSY) ? shift_r[31:24] : buf_r[31:24];
  assign crc_en    = start || (state_r == CCU_BUSY);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || preset)
    begin
      state_r <= CCU_IDLE;
    end
    else
    begin
      case (state_r)
        CCU_IDLE:
        begin
          if (start)
          begin
            state_r <= CCU_BUSY;
          end
        end
        CCU_BUSY:
        begin
          if (last_step)
          begin
            state_r <= CCU_IDLE;
          end
        end
        default:
        begin
          state_r <= CCU_IDLE;
        end
      endcase
    end
  end

  // The counter holds the steps still to run after the one on the start edge.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || preset)
    begin
      cnt_r <= 3'h0;
    end
    else if (start)
    begin
      cnt_r <= `CCU_CALC_CYCLES - 3'h1;
    end
    else if (state_r == CCU_BUSY)
    begin
      cnt_r <= cnt_r - 3'h1;
    end
  end

  // The first byte goes straight from the buffer, so the shift starts one byte on.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || preset)
    begin
      shift_r <= '0;
    end
    else if (start)
    begin
      shift_r <= {buf_r[23:0], 8'h00};
    end
    else if (state_r == CCU_BUSY)
    begin
      shift_r <= {shift_r[23:0], 8'h00};
    end
  end

  ccu_step
  #(
    .BITS (`CCU_BITS_PER_CYC)
  )
  u_step
  (
    .crc_i  (crc_r),
    .data_i (step_in),
    .crc_o  (step_out)
  );

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      crc_r <= `CCU_DATA_RESET;
    end
    else if (preset)
    begin
      crc_r <= `CCU_DATA_RESET;
    end
    else if (crc_en)
    begin
      // Preset outranks a step in flight, so a word being folded is dropped.
      crc_r <= step_out;
    end
  end

  // Control bit reads back set for the one clock after the preset write, then clears.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      preset_r <= 1'b0;
    end
    else
    begin
      preset_r <= preset;
    end
  end

  // ----------------------------------------------------------------
  // Scratch register
  // ----------------------------------------------------------------
  // The byte ignores the preset; only reset and its own writes change it.
  logic [7:0] scr_r;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      scr_r <= `CCU_SCR_RESET;
    end
    else if (wr_scr)
    begin
      scr_r <= wdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Reads load the output register; between reads it holds its last answer.
  ccu_word_t rdata_nxt;

  always_comb
  begin
    rdata_nxt = rdata_o;
    if (rd_data)
    begin
      rdata_nxt = crc_r;
    end
    else if (rd_scr)
    begin
      rdata_nxt = {24'h000000, scr_r};
    end
    else if (rd_ctrl)
    begin
      rdata_nxt = {31'h0, preset_r};
    end
    else if (rd_none)
    begin
      rdata_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  // Busy covers a word waiting in the buffer as well as one being folded in.
  assign busy_o = (state_r == CCU_BUSY) || buf_full_r;

endmodule // ccu_top

//--- ccu_asserts.sv
// Port checker for ccu_top.
// Assumes a bind onto ccu_top and one clock domain.
`timescale 1ns/10ps
module ccu_asserts
(
  input wire logic        sys_clk_i, // Clock
  input wire logic        rst_i,     // Reset
  input wire logic        sel_i,     // Select
  input wire logic        write_i,   // Write
  input wire logic [7:0]  addr_i,    // Offset
  input wire logic [31:0] wdata_i,   // Data in
  input wire logic [31:0] rdata_o,   // Data out
  input wire logic        busy_o     // Busy
);
  logic       dw, cw, rd, sw, dirty_r, cw_r;
  logic [7:0] scr_r;
  logic [3:0] qc_r;
  logic [2:0] hold_r;
  assign dw = sel_i && write_i && addr_i == 8'h00;
  assign sw = sel_i && write_i && addr_i == 8'h04;
  assign cw = sel_i && write_i && addr_i == 8'h08 && wdata_i[0];
  assign rd = sel_i && !write_i;
  // Shadow state: scratch byte, data written since preset, busy window, idle span.
  always_ff @(posedge sys_clk_i)
  begin
    scr_r   <= rst_i ? 8'h00 : sw ? wdata_i[7:0] : scr_r;
    dirty_r <= !rst_i && !cw && (dw || dirty_r);
    cw_r    <= !rst_i && cw;
    qc_r    <= (rst_i || dw) ? 4'h0 : qc_r + {3'h0, qc_r != 4'hF};
    hold_r  <= (rst_i || cw) ? 3'h0 : dw ? 3'h4 : hold_r - {2'h0, hold_r != 3'h0};
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_busy_hold: assert property (hold_r != 3'h0 |-> busy_o)
    else $error("busy dropped early");
  a_busy_done: assert property (qc_r == 4'hC |-> !busy_o)
    else $error("busy stuck");
  a_busy_quiet: assert property (!busy_o && !dw |=> !busy_o)
    else $error("busy without write");
  a_scr_readback: assert property (rd && addr_i == 8'h04 |=> rdata_o == {24'h0, scr_r})
    else $error("scratch mismatch");
  a_ctrl_clear: assert property (rd && addr_i == 8'h08 && !cw_r |=> rdata_o == 32'h0)
    else $error("control bit stuck");
  a_unmap_zero: assert property (rd && addr_i > 8'h08 |=> rdata_o == 32'h0)
    else $error("unmapped read nonzero");
  a_clean_ones: assert property (rd && addr_i == 8'h00 && !dirty_r |=> rdata_o == 32'hFFFFFFFF)
    else $error("preset value wrong");
  a_rdata_hold: assert property (!rd |=> $stable(rdata_o))
    else $error("read data moved");
  c_calc: cover property (dw ##1 busy_o);
  c_preset: cover property (cw ##1 rd);
  c_scr: cover property (rd && addr_i == 8'h04);
endmodule // ccu_asserts
bind ccu_top ccu_asserts u_chk (.sys_clk_i, .rst_i, .sel_i, .write_i, .addr_i, .wdata_i,
  .rdata_o, .busy_o);

//--- ccu_master.sv
// Bus master model issuing word accesses.
// Assumes the unit samples on the rising edge.
`timescale 1ns/10ps
module ccu_master
(
  input  wire logic        clk_i,   // Clock
  input  wire logic [31:0] rdata_i, // Read data
  output logic             sel_o,   // Select
  output logic             write_o, // Write
  output logic [7:0]       addr_o,  // Offset
  output logic [31:0]      wdata_o  // Write data
);
  initial
    {sel_o, write_o, addr_o, wdata_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i);
    {sel_o, write_o, addr_o, wdata_o} = {2'b11, a, d};
    @(posedge clk_i);
  endtask
  // Released lines show inverted garbage.
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge clk_i);
      {sel_o, addr_o, wdata_o} = {1'b0, ~addr_o, ~wdata_o};
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_i);
    {sel_o, write_o, addr_o} = {2'b10, a};
    @(posedge clk_i);
    idle(2);
    d = rdata_i;
  endtask
endmodule // ccu_master

//--- crc32_calc_unit_tb.sv
// Self-checking bench for the checksum unit.
// Assumes the master model and the bound checker.
`timescale 1ns/10ps
`include "ccu_defines.svh"
module crc32_calc_unit_tb;
  logic        sys_clk_i, rst_i, sel_i, write_i, busy_o;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, v, c;
  logic [31:0] w [3] = '{32'h00000000, 32'hFFFFFFFF, 32'h12345678};
  int          bad_count, check_count;
  ccu_top uut (.sys_clk_i, .rst_i, .sel_i, .write_i, .addr_i, .wdata_i, .rdata_o, .busy_o);
  ccu_master mst (.clk_i(sys_clk_i), .rdata_i(rdata_o), .sel_o(sel_i), .write_o(write_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  function automatic logic [31:0] nx(input logic [31:0] s, input logic [31:0] d);
    for (int i = 31; i >= 0; i--)
      s = {s[30:0], 1'b0} ^ ((s[31] ^ d[i]) ? `CCU_POLY : 32'h0);
    return s;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    mst.rd(a, v);
    chk(n, v, e);
  endtask
  task automatic stop_test;
    $display("TB: checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    bad_count++;
    stop_test();
  end
  initial
  begin
    rst_i = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    rst_i = 1'b0;
    rc(8'h00, 32'hFFFFFFFF, "data reset");
    rc(8'h04, 32'h0, "scratch reset");
    rc(8'h08, 32'h0, "control reset");
    rc(8'h0C, 32'h0, "unmapped");
    $display("TB: reset test done");
    c = 32'hFFFFFFFF;
    foreach (w[i])
    begin
      mst.wr(8'h00, w[i]);
      mst.idle(4);
      chk("busy", {31'h0, busy_o}, 32'h1);
      c = nx(c, w[i]);
      rc(8'h00, c, "accumulate");
      chk("done", {31'h0, busy_o}, 32'h0);
    end
    mst.wr(8'h00, 32'hA5A5A5A5);
    mst.idle(1);
    mst.wr(8'h00, 32'h0F0F0F0F);
    mst.idle(10);
    c = nx(nx(c, 32'hA5A5A5A5), 32'h0F0F0F0F);
    rc(8'h00, c, "buffered");
    $display("TB: calc test done");
    mst.wr(8'h04, 32'hFFFFFF5A);
    rc(8'h04, 32'h5A, "scratch");
    mst.wr(8'h00, w[1]);
    mst.wr(8'h08, 32'h1);
    rc(8'h00, 32'hFFFFFFFF, "preset");
    chk("preset idle", {31'h0, busy_o}, 32'h0);
    rc(8'h08, 32'h0, "self clear");
    rc(8'h04, 32'h5A, "scratch kept");
    mst.wr(8'h00, w[2]);
    mst.idle(4);
    rc(8'h00, nx(32'hFFFFFFFF, w[2]), "after preset");
    $display("TB: preset test done");
    stop_test();
  end
endmodule // crc32_calc_unit_tb
